// File: scs_clk_gen.sv
// far-side clock source model: free-running wave with set high and low times
module scs_clk_gen #(
   parameter int PHASE_NS = 3
) (
   input int hiNs,
   input int loNs,
   output logic clk
);
   timeunit 1ns;
   timeprecision 100ps;
   // a phase that is not 4 mod 8 keeps edges off the sampling clock edges
   initial begin
      clk = 1'b0;
      #(PHASE_NS);
      // times may change mid-run; a new value applies from the next edge
      forever begin
         clk = 1'b1;
         #(hiNs);
         clk = 1'b0;
         #(loNs);
      end
   end
endmodule

// File: scs_clock_source.sv
// system clock source selection and output divider
// Contract
// - select 11b passes direct clock pin through
// - select 10b, bypass 1b uses prescaler
// - prescaler divides by divider value plus one
// - factor one passes oscillator clock unchanged
// - largest division factor is 1024
// - select 10b, bypass 0b enables PLL output
// - select 00b runs from wakeup clock
module scs_clock_source #(
   parameter int DIV_W = scs_pkg::DIV_WIDTH
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [1:0] clockSourceSelect,
   input wire logic oscillatorBypass,
   input wire logic oscSourceSelect,
   input wire logic [DIV_W-1:0] outputDividerValue,
   input wire logic directClockInputPin,
   input wire logic crystalInputPin,
   input wire logic internalClock,
   input wire logic pllClock,
   input wire logic wakeupClock,
   output logic systemClock,
   output logic pllEnable,
   output logic [3:0] activeMode
);
   logic [scs_pkg::SYNC_WIDTH-1:0] rawClocks;
   logic [scs_pkg::SYNC_WIDTH-1:0] syncClocks;
   logic dirSync;
   logic xtalSync;
   logic intSync;
   logic pllSync;
   logic wuSync;
   logic oscSync;
   logic oscPrev;
   logic oscRise;
   scs_pkg::scs_mode_t modeReg;
   scs_pkg::scs_mode_t next_mode;
   logic [DIV_W-1:0] divCount;
   logic [DIV_W-1:0] next_divCount;
   logic [DIV_W:0] divFactor;
   logic [DIV_W:0] highSpan;
   logic factorOne;
   logic atTop;
   logic divHigh;
   logic next_systemClock;

   assign rawClocks[scs_pkg::SYNC_DIRECT] = directClockInputPin;
   assign rawClocks[scs_pkg::SYNC_CRYSTAL] = crystalInputPin;
   assign rawClocks[scs_pkg::SYNC_INTERNAL] = internalClock;
   assign rawClocks[scs_pkg::SYNC_PLL] = pllClock;
   assign rawClocks[scs_pkg::SYNC_WAKEUP] = wakeupClock;

   // every source is asynchronous to sys_clk, so all are oversampled
   scs_sync_2ff #(
      .WIDTH(scs_pkg::SYNC_WIDTH)
   ) clockSync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .asyncIn(rawClocks),
      .syncOut(syncClocks)
   );

   assign dirSync = syncClocks[scs_pkg::SYNC_DIRECT];
   assign xtalSync = syncClocks[scs_pkg::SYNC_CRYSTAL];
   assign intSync = syncClocks[scs_pkg::SYNC_INTERNAL];
   assign pllSync = syncClocks[scs_pkg::SYNC_PLL];
   assign wuSync = syncClocks[scs_pkg::SYNC_WAKEUP];

   // oscillator feeding the prescaler: crystal or internal source
   assign oscSync = (oscSourceSelect == scs_pkg::OSC_FROM_INTERNAL) ? intSync : xtalSync;
   assign oscRise = oscSync & ~oscPrev;

   // reserved select code falls back to wakeup, the safest slow clock
   always_comb begin
      case (clockSourceSelect)
         scs_pkg::SEL_DIRECT: next_mode = scs_pkg::MODE_DIRECT;
         scs_pkg::SEL_PLL_OR_PRESCALE: begin
            if (oscillatorBypass == scs_pkg::BYPASS_PRESCALE) begin
               next_mode = scs_pkg::MODE_PRESCALE;
            end else begin
               next_mode = scs_pkg::MODE_PLL;
            end
         end
         scs_pkg::SEL_WAKEUP: next_mode = scs_pkg::MODE_WAKEUP;
         default: next_mode = scs_pkg::MODE_WAKEUP;
      endcase
   end

   // factor is value plus one, so ten bits reach 1024
   assign divFactor = {1'b0, outputDividerValue} + {{DIV_W{1'b0}}, 1'b1};
   // high for the first ceil(factor/2) source periods
   assign highSpan = (divFactor + {{DIV_W{1'b0}}, 1'b1}) >> 1;
   assign factorOne = (outputDividerValue == '0);
   // >= also recovers when the value shrinks mid-count
   assign atTop = (divCount >= outputDividerValue);

   always_comb begin
      next_divCount = divCount;
      // factor one holds at zero, else a count left from a larger value would linger
      if (modeReg != scs_pkg::MODE_PRESCALE || factorOne) begin
         next_divCount = '0;
      end else if (oscRise) begin
         if (atTop) begin
            next_divCount = '0;
         end else begin
            next_divCount = divCount + {{(DIV_W-1){1'b0}}, 1'b1};
         end
      end
   end

   assign divHigh = ({1'b0, next_divCount} < highSpan);

   always_comb begin
      case (modeReg)
         scs_pkg::MODE_DIRECT: next_systemClock = dirSync;
         scs_pkg::MODE_PRESCALE: next_systemClock = factorOne ? oscSync : divHigh;
         scs_pkg::MODE_PLL: next_systemClock = pllSync;
         scs_pkg::MODE_WAKEUP: next_systemClock = wuSync;
         default: next_systemClock = wuSync;
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         modeReg <= scs_pkg::MODE_WAKEUP;
         oscPrev <= 1'b0;
         divCount <= '0;
      end else begin
         modeReg <= next_mode;
         oscPrev <= oscSync;
         divCount <= next_divCount;
      end
   end

   // outputs straight from flip-flops
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         systemClock <= 1'b0;
         pllEnable <= 1'b0;
         activeMode <= scs_pkg::MODE_WAKEUP;
      end else begin
         systemClock <= next_systemClock;
         pllEnable <= (next_mode == scs_pkg::MODE_PLL);
         activeMode <= next_mode;
      end
   end

   sequence directSel_s;
      clockSourceSelect == scs_pkg::SEL_DIRECT;
   endsequence

   sequence prescaleSel_s;
      clockSourceSelect == scs_pkg::SEL_PLL_OR_PRESCALE && oscillatorBypass;
   endsequence

   sequence wrapEdge_s;
      modeReg == scs_pkg::MODE_PRESCALE && oscRise && divCount == outputDividerValue;
   endsequence

   sequence wrapAny_s;
      modeReg == scs_pkg::MODE_PRESCALE && oscRise && !factorOne && atTop;
   endsequence

   direct_pass_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      directSel_s ##1 (modeReg == scs_pkg::MODE_DIRECT) |=> systemClock == $past(dirSync))
      else $error("direct mode output does not follow clock pin");

   prescale_sel_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      prescaleSel_s |=> modeReg == scs_pkg::MODE_PRESCALE && !pllEnable
         && activeMode == scs_pkg::MODE_PRESCALE)
      else $error("prescaler mode not entered");

   divide_wrap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      wrapEdge_s ##1 (modeReg == scs_pkg::MODE_PRESCALE) |-> divCount == '0)
      else $error("divider count did not wrap at divider value");

   divide_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      modeReg == scs_pkg::MODE_PRESCALE && oscRise && divCount < outputDividerValue
      ##1 modeReg == scs_pkg::MODE_PRESCALE |-> divCount == $past(divCount) + 1'b1)
      else $error("divider count did not advance on source edge");

   factor_one_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      modeReg == scs_pkg::MODE_PRESCALE && factorOne |=> systemClock == $past(oscSync))
      else $error("factor one does not pass oscillator through");

   max_factor_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      modeReg == scs_pkg::MODE_PRESCALE && oscRise && &outputDividerValue
      && divCount == (DIV_W)'(scs_pkg::DIV_FACTOR_MAX - 2)
      ##1 modeReg == scs_pkg::MODE_PRESCALE |-> &divCount)
      else $error("divider cannot reach factor 1024");

   zero_value_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      modeReg == scs_pkg::MODE_PRESCALE && factorOne && $stable(outputDividerValue)
      ##1 modeReg == scs_pkg::MODE_PRESCALE |-> divCount == '0)
      else $error("zero divider value must hold count at zero");

   pll_enable_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      clockSourceSelect == scs_pkg::SEL_PLL_OR_PRESCALE && !oscillatorBypass
      |=> pllEnable && modeReg == scs_pkg::MODE_PLL ##1 systemClock == $past(pllSync))
      else $error("PLL mode not enabled or not routed");

   wakeup_run_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      clockSourceSelect == scs_pkg::SEL_WAKEUP
      |=> !pllEnable && modeReg == scs_pkg::MODE_WAKEUP ##1 systemClock == $past(wuSync))
      else $error("wakeup mode not routed undivided");

   reserved_fallback_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      clockSourceSelect == scs_pkg::SEL_RESERVED
      |=> modeReg == scs_pkg::MODE_WAKEUP && activeMode == scs_pkg::MODE_WAKEUP
         && !pllEnable)
      else $error("reserved select does not fall back to wakeup");

   mode_onehot_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $onehot(activeMode) && pllEnable == (activeMode == scs_pkg::MODE_PLL))
      else $error("mode flags not one-hot or PLL enable mismatched");

   wrap_high_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      wrapAny_s |=> systemClock)
      else $error("system clock not high at start of divided period");

   div_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      modeReg != scs_pkg::MODE_PRESCALE |=> divCount == '0)
      else $error("divider count not cleared outside prescaler mode");
endmodule

// File: scs_pkg.sv
// constants shared by the system clock source divider
package scs_pkg;
   localparam logic [1:0] SEL_WAKEUP = 2'h0;
   localparam logic [1:0] SEL_RESERVED = 2'h1;
   localparam logic [1:0] SEL_PLL_OR_PRESCALE = 2'h2;
   localparam logic [1:0] SEL_DIRECT = 2'h3;
   localparam logic BYPASS_PLL = 1'h0;
   localparam logic BYPASS_PRESCALE = 1'h1;
   localparam logic OSC_FROM_CRYSTAL = 1'h0;
   localparam logic OSC_FROM_INTERNAL = 1'h1;
   localparam int DIV_WIDTH = 10;
   localparam int DIV_FACTOR_MAX = 1024;
   localparam int SYNC_WIDTH = 5;
   localparam int SYNC_DIRECT = 0;
   localparam int SYNC_CRYSTAL = 1;
   localparam int SYNC_INTERNAL = 2;
   localparam int SYNC_PLL = 3;
   localparam int SYNC_WAKEUP = 4;
   typedef enum logic [3:0] {
      MODE_WAKEUP = 4'h1,
      MODE_PLL = 4'h2,
      MODE_PRESCALE = 4'h4,
      MODE_DIRECT = 4'h8
   } scs_mode_t;
endpackage

// File: scs_sync_2ff.sv
// two flip-flop synchroniser for a bundle of asynchronous levels
module scs_sync_2ff #(
   parameter int WIDTH = 1
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1;

   // first stage feeds only the second stage
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stage1 <= '0;
         syncOut <= '0;
      end else begin
         stage1 <= asyncIn;
         syncOut <= stage1;
      end
   end
endmodule

// File: tb_system_clock_source_divider.sv
// self-checking bench for the system clock source divider
module tb_system_clock_source_divider;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk, sys_rst, oscillatorBypass, oscSourceSelect;
   logic [1:0] clockSourceSelect;
   logic [9:0] outputDividerValue;
   logic directClockInputPin, crystalInputPin, internalClock, pllClock, wakeupClock;
   logic systemClock, pllEnable;
   logic [3:0] activeMode;
   int fail_count = 0;
   int n_tests = 0;
   // keep every time a multiple of the 8 ns period so edges stay off sampling edges
   int dirHi = 24;
   int dirLo = 56;
   int xtlHi = 24;
   int xtlLo = 40;
   int intHalf = 48;
   int pllHalf = 64;
   int wuHalf = 80;
   scs_clk_gen #(.PHASE_NS(3)) dirGen (.hiNs(dirHi), .loNs(dirLo), .clk(directClockInputPin));
   scs_clk_gen #(.PHASE_NS(5)) xtlGen (.hiNs(xtlHi), .loNs(xtlLo), .clk(crystalInputPin));
   scs_clk_gen #(.PHASE_NS(2)) intGen (.hiNs(intHalf), .loNs(intHalf), .clk(internalClock));
   scs_clk_gen #(.PHASE_NS(6)) pllGen (.hiNs(pllHalf), .loNs(pllHalf), .clk(pllClock));
   scs_clk_gen #(.PHASE_NS(1)) wuGen (.hiNs(wuHalf), .loNs(wuHalf), .clk(wakeupClock));
   scs_clock_source uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .clockSourceSelect(clockSourceSelect), .oscillatorBypass(oscillatorBypass),
      .oscSourceSelect(oscSourceSelect), .outputDividerValue(outputDividerValue),
      .directClockInputPin(directClockInputPin), .crystalInputPin(crystalInputPin),
      .internalClock(internalClock), .pllClock(pllClock), .wakeupClock(wakeupClock),
      .systemClock(systemClock), .pllEnable(pllEnable), .activeMode(activeMode));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cfg(input logic [1:0] sel, input logic byp, input logic osc,
                      input logic [9:0] div);
      @(posedge sys_clk);
      #1;
      clockSourceSelect = sel;
      oscillatorBypass = byp;
      oscSourceSelect = osc;
      outputDividerValue = div;
      repeat (4) @(posedge sys_clk);
      #1;
   endtask
   // bounded wait while the output holds one level, counting cycles
   task automatic span(input logic lvl, output int n);
      n = 0;
      while (systemClock === lvl && n < 20000) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
   endtask
   // first two periods after a change are thrown away, the first may be partial
   task automatic measure(output int per, output int hi);
      int lo, d;
      span(1'b1, d);
      span(1'b0, d);
      span(1'b1, d);
      span(1'b0, d);
      span(1'b1, hi);
      span(1'b0, lo);
      per = hi + lo;
   endtask
   task automatic expect_wave(input int ePer, input int eHi);
      int per, hi;
      measure(per, hi);
      check(16'(per), 16'(ePer));
      check(16'(hi), 16'(eHi));
   endtask
   task automatic t_direct(input int ePer, input int eHi);
      cfg(scs_pkg::SEL_DIRECT, 1'b0, 1'b0, 10'h3ff);
      check(16'(activeMode), 16'(scs_pkg::MODE_DIRECT));
      check(16'(pllEnable), 16'h0);
      expect_wave(ePer, eHi);
   endtask
   task automatic t_wakeup();
      cfg(scs_pkg::SEL_WAKEUP, 1'b1, 1'b0, 10'h002);
      check(16'(activeMode), 16'(scs_pkg::MODE_WAKEUP));
      expect_wave(20, 10);
      cfg(scs_pkg::SEL_RESERVED, 1'b1, 1'b0, 10'h002);
      check(16'(activeMode), 16'(scs_pkg::MODE_WAKEUP));
   endtask
   task automatic t_pll();
      cfg(scs_pkg::SEL_PLL_OR_PRESCALE, scs_pkg::BYPASS_PLL, 1'b0, 10'h002);
      check(16'(activeMode), 16'(scs_pkg::MODE_PLL));
      check(16'(pllEnable), 16'h1);
      expect_wave(16, 8);
   endtask
   task automatic t_prescale();
      logic osc [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
      logic [9:0] div [4] = '{10'h000, 10'h002, 10'h000, 10'h3ff};
      int ePer [4] = '{8, 24, 12, 8192};
      int eHi [4] = '{3, 16, 6, 4096};
      for (int i = 0; i < 4; i++) begin
         cfg(scs_pkg::SEL_PLL_OR_PRESCALE, scs_pkg::BYPASS_PRESCALE, osc[i], div[i]);
         check(16'(activeMode), 16'(scs_pkg::MODE_PRESCALE));
         check(16'(pllEnable), 16'h0);
         expect_wave(ePer[i], eHi[i]);
      end
   endtask
   // longest run is up to three slowest periods plus setup; generous margin
   initial begin
      #600000;
      fail_count++;
      summarize();
   end
   initial begin
      sys_rst = 1'b1;
      clockSourceSelect = 2'h0;
      oscillatorBypass = 1'b0;
      oscSourceSelect = 1'b0;
      outputDividerValue = 10'h000;
      repeat (16) @(posedge sys_clk);
      #1;
      sys_rst = 1'b0;
      t_direct(10, 3);
      t_wakeup();
      t_pll();
      t_prescale();
      // new pin duty: output must follow the changed high time
      dirHi = 16;
      dirLo = 48;
      t_direct(8, 2);
      summarize();
   end
endmodule
